// file: shared/pbmux_pkg.sv
package pbmux_pkg;
	localparam int NUM_BITS = 8;
	localparam int BIT_CHIP_OSC_OUT = 7;
	localparam int BIT_CHIP_OSC_IN = 6;
	localparam int BIT_SCK = 5;
	localparam int BIT_MISO = 4;
	localparam int BIT_MOSI = 3;
	localparam int BIT_SEL = 2;
	localparam int BIT_TIMER1_COMPARE_A_OUT = 1;
	localparam int FIRST_MUXED_BIT = 1;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	// pull-up pattern {dir, out, global disable}
	localparam logic [2:0] PULLUP_PATTERN = 3'h2;
	typedef enum logic [1:0]
	{
		PBMUX_CLK_INT_RC = 2'h0,
		PBMUX_CLK_CRYSTAL = 2'h1,
		PBMUX_CLK_EXTERNAL = 2'h2
	} pbmux_clk_src_t;
endpackage

// file: rtl/pbmux_sync.sv
`timescale 1ns/1ps
module pbmux_sync
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic async_i,
	output logic sync_o
);
	logic [1:0] stage_q;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			stage_q <= pbmux_pkg::SYNC_RESET;
		end
		else
		begin
			stage_q <= {stage_q[0], async_i};
		end
	end

	assign sync_o = stage_q[1];
endmodule

// file: rtl/pbmux_port_b_mux.sv
`timescale 1ns/1ps
module pbmux_port_b_mux
#(
	parameter int WIDTH = pbmux_pkg::NUM_BITS
)
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] clk_src_i,
	input wire logic async_timer_select_i,
	input wire logic external_clock_select_i,
	input wire logic global_pullup_disable_i,
	input wire logic dir_we_i,
	input wire logic [WIDTH-1:0] dir_wdata_i,
	input wire logic out_we_i,
	input wire logic [WIDTH-1:0] out_wdata_i,
	output logic [WIDTH-1:0] dir_rdata_o,
	output logic [WIDTH-1:0] out_rdata_o,
	output logic [WIDTH-1:0] in_rdata_o,
	input wire logic spi_enable_i,
	input wire logic spi_master_i,
	input wire logic spi_sck_out_i,
	input wire logic spi_slave_out_i,
	input wire logic spi_master_out_i,
	output logic spi_sck_in_o,
	output logic spi_master_in_o,
	output logic spi_slave_in_o,
	output logic spi_slave_active_o,
	input wire logic timer2_compare_a_en_i,
	input wire logic timer2_compare_a_out_i,
	input wire logic timer1_compare_b_en_i,
	input wire logic timer1_compare_b_out_i,
	input wire logic timer1_compare_a_en_i,
	input wire logic timer1_compare_a_out_i,
	output logic [WIDTH-1:0] pin_change_src_o,
	output logic chip_osc_output_pin_o,
	output logic chip_osc_input_pin_o,
	output logic timer_osc_output_pin_o,
	output logic timer_osc_input_pin_o,
	input wire logic [WIDTH-1:0] pad_i,
	output logic [WIDTH-1:0] pad_o,
	output logic [WIDTH-1:0] pad_oe_o,
	output logic [WIDTH-1:0] pad_pullup_o
);
	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] pad_sync;
	logic int_rc;
	logic bit7_clock;
	logic bit6_clock;
	logic timer_osc_ok;
	logic spi_slave;
	logic spi_mstr;
	logic [WIDTH-1:0] clock_mask;
	logic [WIDTH-1:0] direction_override_enable;
	logic [WIDTH-1:0] direction_override_value;
	logic [WIDTH-1:0] value_override_enable;
	logic [WIDTH-1:0] value_override_value;
	logic [WIDTH-1:0] pullup_override_enable;
	logic [WIDTH-1:0] puov;
	logic [WIDTH-1:0] drive_en;
	logic [WIDTH-1:0] direction_override_enable_spi;
	logic [WIDTH-1:0] value_override_enable_raw;
	logic [WIDTH-1:0] value_override_value_raw;
	logic [WIDTH-1:0] pullup_override_enable_raw;
	logic [WIDTH-1:0] puov_raw;

	function automatic logic pick(input logic sel, input logic ov, input logic reg_v);
		pick = sel ? ov : reg_v;
	endfunction

	// crystal source decode, shared by the bit 7 role and its flag
	function automatic logic is_crystal(input logic [1:0] src);
		is_crystal = (src == pbmux_pkg::PBMUX_CLK_CRYSTAL);
	endfunction

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			dir_q <= pbmux_pkg::DIR_RESET;
		end
		else if (dir_we_i)
		begin
			dir_q <= dir_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			out_q <= pbmux_pkg::PORT_RESET;
		end
		else if (out_we_i)
		begin
			out_q <= out_wdata_i;
		end
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_sync
			pbmux_sync u_sync
			(
				.core_clk_i(core_clk_i),
				.rst_b_i(rst_b_i),
				.async_i(pad_i[g]),
				.sync_o(pad_sync[g])
			);
		end
	endgenerate

	assign int_rc = (clk_src_i == pbmux_pkg::PBMUX_CLK_INT_RC);
	// timer oscillator needs internal RC chip clock and async timer
	assign timer_osc_ok = int_rc && async_timer_select_i;
	// bit 7: crystal output for crystal source only, or timer osc out
	assign bit7_clock = is_crystal(clk_src_i)
		|| (timer_osc_ok && !external_clock_select_i);
	// bit 6: chip clock input for any non-RC source, or timer osc input
	assign bit6_clock = !int_rc || timer_osc_ok;
	assign spi_slave = spi_enable_i && !spi_master_i;
	assign spi_mstr = spi_enable_i && spi_master_i;

	always_comb
	begin
		clock_mask = '0;
		clock_mask[pbmux_pkg::BIT_CHIP_OSC_OUT] = bit7_clock;
		clock_mask[pbmux_pkg::BIT_CHIP_OSC_IN] = bit6_clock;
	end

	// direction overrides: SPI forces its input pins
	always_comb
	begin
		direction_override_enable_spi = '0;
		direction_override_enable_spi[pbmux_pkg::BIT_SCK] = spi_slave;
		direction_override_enable_spi[pbmux_pkg::BIT_MISO] = spi_mstr;
		direction_override_enable_spi[pbmux_pkg::BIT_MOSI] = spi_slave;
		direction_override_enable_spi[pbmux_pkg::BIT_SEL] = spi_slave;
	end

	// value overrides from SPI and the timers
	always_comb
	begin
		value_override_enable_raw = '0;
		value_override_value_raw = '0;
		value_override_enable_raw[pbmux_pkg::BIT_SCK] = spi_mstr;
		value_override_value_raw[pbmux_pkg::BIT_SCK] = spi_sck_out_i;
		value_override_enable_raw[pbmux_pkg::BIT_MISO] = spi_slave;
		value_override_value_raw[pbmux_pkg::BIT_MISO] = spi_slave_out_i;
		// compare outputs only reach the pad when direction is output
		value_override_enable_raw[pbmux_pkg::BIT_MOSI] = spi_mstr || timer2_compare_a_en_i;
		value_override_value_raw[pbmux_pkg::BIT_MOSI] = spi_mstr ? spi_master_out_i : timer2_compare_a_out_i;
		value_override_enable_raw[pbmux_pkg::BIT_SEL] = timer1_compare_b_en_i;
		value_override_value_raw[pbmux_pkg::BIT_SEL] = timer1_compare_b_out_i;
		value_override_enable_raw[pbmux_pkg::BIT_TIMER1_COMPARE_A_OUT] = timer1_compare_a_en_i;
		value_override_value_raw[pbmux_pkg::BIT_TIMER1_COMPARE_A_OUT] = timer1_compare_a_out_i;
	end

	// forced inputs keep output-bit pull-up unless globally disabled
	always_comb
	begin
		pullup_override_enable_raw = '0;
		pullup_override_enable_raw[pbmux_pkg::BIT_SCK] = spi_slave;
		pullup_override_enable_raw[pbmux_pkg::BIT_MISO] = spi_mstr;
		pullup_override_enable_raw[pbmux_pkg::BIT_MOSI] = spi_slave;
		pullup_override_enable_raw[pbmux_pkg::BIT_SEL] = spi_slave;
		puov_raw = out_q & {WIDTH{!global_pullup_disable_i}};
	end

	// oscillator roles win over everything else
	always_comb
	begin
		direction_override_enable = direction_override_enable_spi | clock_mask;
		direction_override_value = '0;
		value_override_enable = value_override_enable_raw & ~clock_mask;
		value_override_value = value_override_value_raw;
		pullup_override_enable = pullup_override_enable_raw | clock_mask;
		puov = puov_raw & ~clock_mask;
	end

	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_pin
			// driver from direction override or direction bit
			assign drive_en[g] = pick(direction_override_enable[g], direction_override_value[g], dir_q[g]);
			// pad value from value override or output bit
			assign pad_o[g] = drive_en[g] && pick(value_override_enable[g], value_override_value[g], out_q[g]);
			assign pad_oe_o[g] = drive_en[g];
			// pull-up pattern when not overridden
			assign pad_pullup_o[g] = pullup_override_enable[g] ? puov[g]
				: ({dir_q[g], out_q[g], global_pullup_disable_i} == pbmux_pkg::PULLUP_PATTERN);
		end
	endgenerate

	// clock pins read back as zero
	assign dir_rdata_o = dir_q & ~clock_mask;
	assign out_rdata_o = out_q & ~clock_mask;
	assign in_rdata_o = pad_sync & ~clock_mask;
	// bits 7..1 feed pin-change sources; clock pins do not
	assign pin_change_src_o = {pad_sync[WIDTH-1:pbmux_pkg::FIRST_MUXED_BIT] &
		~clock_mask[WIDTH-1:pbmux_pkg::FIRST_MUXED_BIT], 1'b0};

	assign spi_sck_in_o = pad_sync[pbmux_pkg::BIT_SCK];
	assign spi_master_in_o = pad_sync[pbmux_pkg::BIT_MISO];
	assign spi_slave_in_o = pad_sync[pbmux_pkg::BIT_MOSI];
	// slave only active while select held low
	assign spi_slave_active_o = spi_slave && !pad_sync[pbmux_pkg::BIT_SEL];

	assign chip_osc_output_pin_o = is_crystal(clk_src_i);
	assign chip_osc_input_pin_o = !int_rc;
	assign timer_osc_output_pin_o = timer_osc_ok && !external_clock_select_i;
	assign timer_osc_input_pin_o = timer_osc_ok;
endmodule

// file: dv/pbmux_far.sv
`timescale 1ns/1ps
module pbmux_far
(
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] line_o
);
	// driven bits win, then pull-ups, else the outside party's level
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			line_o[i] = oe_i[i] ? drv_i[i] : (pu_i[i] | ext_i[i]);
	end
endmodule

// file: dv/pbmux_assertions.sv
`timescale 1ns/1ps
module pbmux_checker
#(
	parameter int WIDTH = 8
)
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] clk_src_i,
	input wire logic async_timer_select_i,
	input wire logic external_clock_select_i,
	input wire logic spi_enable_i,
	input wire logic spi_master_i,
	input wire logic timer_osc_output_pin_o,
	input wire logic timer_osc_input_pin_o,
	input wire logic chip_osc_input_pin_o,
	input wire logic spi_slave_active_o,
	input wire logic [WIDTH-1:0] dir_rdata_o,
	input wire logic [WIDTH-1:0] pin_change_src_o,
	input wire logic [WIDTH-1:0] pad_i,
	input wire logic [WIDTH-1:0] pad_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_b7;
		timer_osc_output_pin_o |-> !pad_oe_o[7] && !dir_rdata_o[7] && !pin_change_src_o[7];
	endproperty
	a_b7: assert property (p_b7) else $error("bit7 not detached");
	property p_timer_osc_output_pin;
		timer_osc_output_pin_o == (clk_src_i == 2'h0 && async_timer_select_i
			&& !external_clock_select_i);
	endproperty
	a_timer_osc_output_pin: assert property (p_timer_osc_output_pin) else $error("bit7 timer role");
	property p_chip_osc_input_pin;
		chip_osc_input_pin_o == (clk_src_i != 2'h0);
	endproperty
	a_chip_osc_input_pin: assert property (p_chip_osc_input_pin) else $error("bit6 chip role");
	property p_timer_osc_input_pin;
		timer_osc_input_pin_o == (clk_src_i == 2'h0 && async_timer_select_i);
	endproperty
	a_timer_osc_input_pin: assert property (p_timer_osc_input_pin) else $error("bit6 timer role");
	property p_slv;
		spi_enable_i && !spi_master_i |-> !pad_oe_o[5] && !pad_oe_o[3] && !pad_oe_o[2];
	endproperty
	a_slv: assert property (p_slv) else $error("slave pins driven");
	property p_mst;
		spi_enable_i && spi_master_i |-> !pad_oe_o[4];
	endproperty
	a_mst: assert property (p_mst) else $error("master input driven");
	property p_sync;
		$stable(pad_i)[*3] ##0 $past(rst_b_i) && $past(rst_b_i, 2)
			|-> pin_change_src_o[5:1] == pad_i[5:1] && !pin_change_src_o[0];
	endproperty
	a_sync: assert property (p_sync) else $error("pin change tap");
	property p_act;
		spi_slave_active_o |-> spi_enable_i && !spi_master_i && !pin_change_src_o[2];
	endproperty
	a_act: assert property (p_act) else $error("slave active");
	cover property (timer_osc_output_pin_o);
	cover property (spi_slave_active_o);
	cover property (chip_osc_input_pin_o);
endmodule
bind pbmux_port_b_mux pbmux_checker #(.WIDTH(WIDTH)) u_chk (.*);

// file: dv/pbmux_port_b_mux_bench.sv
`timescale 1ns/1ps
module pbmux_port_b_mux_bench;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic async_timer_select_i, external_clock_select_i, global_pullup_disable_i, dir_we_i;
	logic out_we_i, spi_enable_i, spi_master_i, spi_sck_out_i, spi_slave_out_i;
	logic spi_master_out_i, timer2_compare_a_en_i, timer2_compare_a_out_i;
	logic timer1_compare_b_en_i, timer1_compare_b_out_i, timer1_compare_a_en_i;
	logic timer1_compare_a_out_i, spi_sck_in_o, spi_master_in_o, spi_slave_in_o;
	logic spi_slave_active_o, chip_osc_output_pin_o, chip_osc_input_pin_o;
	logic timer_osc_output_pin_o, timer_osc_input_pin_o, c7, c6;
	logic [1:0] clk_src_i;
	logic [7:0] dir_wdata_i, out_wdata_i, dir_rdata_o, out_rdata_o, in_rdata_o, pad_i, pad_o;
	logic [7:0] pin_change_src_o, pad_oe_o, pad_pullup_o, ext, dq, oq, m, f, oe, val, pu, pad;
	logic [41:0] stim = '0;
	int seed = 96;
	int err_total = 0;
	int checks = 0;
	assign {ext, dir_wdata_i, out_wdata_i, clk_src_i, async_timer_select_i,
		external_clock_select_i, global_pullup_disable_i, spi_enable_i, spi_master_i,
		spi_sck_out_i, spi_slave_out_i, spi_master_out_i, timer2_compare_a_en_i,
		timer2_compare_a_out_i, timer1_compare_b_en_i, timer1_compare_b_out_i,
		timer1_compare_a_en_i, timer1_compare_a_out_i, dir_we_i, out_we_i} = stim;
	pbmux_port_b_mux dut (.*);
	pbmux_far far (.drv_i(pad_o), .oe_i(pad_oe_o), .pu_i(pad_pullup_o), .ext_i(ext),
		.line_o(pad_i));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("err_total %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		#100000;
		err_total++;
		print_verdict;
	end
	initial
	begin
		dq = 8'h00;
		oq = 8'h00;
		repeat (8) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (400)
		begin
			@(posedge core_clk_i);
			stim <= 42'({$random(seed), $random(seed)});
			@(posedge core_clk_i);
			if (dir_we_i) dq = dir_wdata_i;
			if (out_we_i) oq = out_wdata_i;
			stim[1:0] <= 2'h0;
			repeat (2) @(posedge core_clk_i);
			#1;
			c7 = clk_src_i == 2'h1
				|| (clk_src_i == 2'h0 && async_timer_select_i && !external_clock_select_i);
			c6 = clk_src_i != 2'h0 || async_timer_select_i;
			m = ~{c7, c6, 6'h00};
			f = !spi_enable_i ? 8'h00 : spi_master_i ? 8'h10 : 8'h2C;
			oe = dq & ~f & m;
			pu = ((f & oq) | (~dq & oq & ~f)) & m & {8{!global_pullup_disable_i}};
			val = oq;
			if (timer2_compare_a_en_i) val[3] = timer2_compare_a_out_i;
			if (timer1_compare_b_en_i) val[2] = timer1_compare_b_out_i;
			if (timer1_compare_a_en_i) val[1] = timer1_compare_a_out_i;
			if (spi_enable_i && spi_master_i) val[5] = spi_sck_out_i;
			if (spi_enable_i && spi_master_i) val[3] = spi_master_out_i;
			if (spi_enable_i && !spi_master_i) val[4] = spi_slave_out_i;
			pad = (oe & val) | (~oe & (pu | ext));
			cmp(dir_rdata_o, dq & m);
			cmp(out_rdata_o, oq & m);
			cmp(in_rdata_o, pad & m);
			cmp(pad_oe_o, oe);
			cmp(pad_o & oe, val & oe);
			cmp(pad_pullup_o, pu);
			cmp(pin_change_src_o, pad & m & 8'hFE);
			cmp({chip_osc_output_pin_o, chip_osc_input_pin_o, timer_osc_output_pin_o,
				timer_osc_input_pin_o, spi_sck_in_o, spi_master_in_o, spi_slave_in_o,
				spi_slave_active_o}, {clk_src_i == 2'h1, clk_src_i != 2'h0,
				clk_src_i == 2'h0 && async_timer_select_i && !external_clock_select_i,
				clk_src_i == 2'h0 && async_timer_select_i, pad[5], pad[4], pad[3],
				spi_enable_i && !spi_master_i && !pad[2]});
		end
		print_verdict;
	end
endmodule
